// ---- logic/field_check_if.sv ----
// field check signals between interpreter and field checker
`timescale 1ns/1ps
`default_nettype none
interface field_check_if;
    logic [7:0]  mode_type;
    logic [15:0] size;
    logic [31:0] addr;
    logic        warn;
    logic [11:0] warn_code;
    logic [1:0]  byte_off;
    logic [2:0]  nbytes;

    modport checker_mp (input mode_type, size, addr,
                        output warn, warn_code, byte_off, nbytes);
    modport user_mp    (output mode_type, size, addr,
                        input warn, warn_code, byte_off, nbytes);
endinterface : field_check_if
`default_nettype wire

// ---- logic/mem_field_check.sv ----
// address, mode/data type and size validation of a memory command
`timescale 1ns/1ps
`default_nettype none
module mem_field_check
    import servo_mem_pkg::*;
(
    field_check_if.checker_mp fc
);

    // ==========================================================
    // bytes per element, zero for a type outside the set
    function automatic logic [2:0] type_bytes(input logic [7:0] mt);
        case (mt)
            MT_BYTE:  type_bytes = 3'h1;
            MT_SHORT: type_bytes = 3'h2;
            MT_LONG:  type_bytes = 3'h4;
            default:  type_bytes = 3'h0;
        endcase
    endfunction : type_bytes

    logic [31:0] off;
    logic [31:0] total;
    logic [2:0]  tb;

    // ==========================================================
    // checks in priority order: address, type, size
    always_comb
    begin
        off          = fc.addr - VMEM_BASE;
        tb           = type_bytes(fc.mode_type);
        total        = {16'h0000, fc.size} * {29'h0, tb};
        fc.byte_off  = off[1:0];
        fc.nbytes    = total[2:0];
        fc.warn      = 1'b1;
        if (fc.addr < VMEM_BASE || off >= VMEM_BYTES)
            fc.warn_code = WARN_ADDR;
        else if (tb == 3'h0)
            fc.warn_code = WARN_TYPE;
        else if (fc.size == 16'h0000 || total > VMEM_BYTES - off
                 || fc.size > 16'h0004)
            fc.warn_code = WARN_SIZE;
        else
        begin
            fc.warn      = 1'b0;
            fc.warn_code = WARN_NONE;
        end
    end

endmodule : mem_field_check
`default_nettype wire

// ---- logic/servo_mem_pkg.sv ----
// constants and types for the memory read/write command interpreter
package servo_mem_pkg;

    // ==========================================================
    // command codes and virtual memory map
    localparam logic [7:0]  CMD_MEM_READ  = 8'h1d;
    localparam logic [7:0]  CMD_MEM_WRITE = 8'h1e;
    localparam logic [31:0] VMEM_BASE     = 32'h8000_4000;
    localparam logic [31:0] VMEM_BYTES    = 32'h0000_0004;
    localparam logic [31:0] ADJ_REQ_ADDR  = 32'h8000_4000;
    localparam logic [31:0] ADJ_CTRL_ADDR = 32'h8000_4002;

    // ==========================================================
    // mode/data type values: byte, short, long
    localparam logic [7:0] MT_BYTE  = 8'h11;
    localparam logic [7:0] MT_SHORT = 8'h12;
    localparam logic [7:0] MT_LONG  = 8'h13;

    // ==========================================================
    // warning codes
    localparam logic [11:0] WARN_NONE = 12'h000;
    localparam logic [11:0] WARN_ADDR = 12'h94a;
    localparam logic [11:0] WARN_TYPE = 12'h94b;
    localparam logic [11:0] WARN_SIZE = 12'h94d;
    localparam logic [11:0] WARN_COND = 12'h95a;

    // ==========================================================
    // adjustment request codes, control values, status values
    localparam logic [15:0] REQ_NORMAL   = 16'h0000;
    localparam logic [15:0] REQ_PRM_INIT = 16'h1005;
    localparam logic [15:0] REQ_ABS_SET  = 16'h1008;
    localparam logic [15:0] REQ_CUR_OFS  = 16'h100e;
    localparam logic [15:0] REQ_MTURN    = 16'h1013;
    localparam logic [15:0] REQ_RST      = 16'h0000;
    localparam logic [15:0] CTRL_EXEC    = 16'h0001;
    localparam logic [15:0] CTRL_PREP    = 16'h0002;
    localparam logic [15:0] ADJ_ST_IDLE  = 16'h0000;
    localparam logic [15:0] ADJ_ST_BUSY  = 16'h0001;
    localparam logic [15:0] ADJ_ST_PREP  = 16'h0002;

    // ==========================================================
    // phases and timing
    localparam logic [1:0] PHASE_2 = 2'h2;
    localparam logic [1:0] PHASE_3 = 2'h3;
    localparam int CLK_HZ        = 20_000_000;
    localparam int INIT_TIME_S   = 20;
    localparam int ADJ_TIME_S    = 5;
    localparam int READ_TIME_MS  = 200;
    localparam int INIT_CYC      = INIT_TIME_S * CLK_HZ;
    localparam int ADJ_CYC       = ADJ_TIME_S * CLK_HZ;
    localparam int READ_CYC      = READ_TIME_MS * (CLK_HZ / 1000);

    // ==========================================================
    // adjustment engine states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_BUSY = 2'b10
    } adj_state_e;

endpackage : servo_mem_pkg

// ---- logic/servo_memory_access_cmds.sv ----
// memory read/write command interpreter with adjustment sequencer
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - read returns data and echoes fields
// - write stores data and echoes fields
// - rejected read warns, data zero
// - rejected write warns, nothing stored
// - bad address gives warning 94A
// - bad mode/data type gives 94B
// - bad size gives 94D
// - editing refuses memory commands with 95A
// - unmet adjustment condition refused with 95A
// - 1005H initializes parameters, not servo on
// - 1008H encoder setup, prepared, absolute, servo off
// - 100EH offset adjust needs power, stopped, off
// - 1013H multiturn limit, prepared, needs restart
// - init and setup need restart to apply
// - ready returns when step done; controller waits
module servo_memory_access_cmds
    import servo_mem_pkg::*;
#(
    parameter int INIT_TIMEOUT_CYC = INIT_CYC,
    parameter int ADJ_TIMEOUT_CYC  = ADJ_CYC
)(
    // clock and reset
    input  wire logic        clk_sys_in,
    input  wire logic        rst_n_in,
    // decoded command frame
    input  wire logic        cmd_valid_in,
    input  wire logic [7:0]  cmd_code_in,
    input  wire logic [7:0]  cmd_mode_type_in,
    input  wire logic [15:0] cmd_size_in,
    input  wire logic [31:0] cmd_addr_in,
    input  wire logic [31:0] cmd_data_in,
    // amplifier state
    input  wire logic [1:0]  phase_in,
    input  wire logic        editing_in,
    input  wire logic        servo_on_in,
    input  wire logic        main_power_in,
    input  wire logic        motor_rotating_in,
    input  wire logic        incremental_enc_in,
    input  wire logic        adj_done_in,
    // response frame
    output logic             rsp_valid_out,
    output logic [7:0]       rsp_code_out,
    output logic [7:0]       rsp_mode_type_out,
    output logic [15:0]      rsp_size_out,
    output logic [31:0]      rsp_addr_out,
    output logic [31:0]      rsp_data_out,
    output logic             warn_valid_out,
    output logic [11:0]      warn_code_out,
    output logic             command_ready_flag_out,
    // adjustment engine
    output logic [3:0]       adj_start_out,
    output logic             restart_required_out
);

    if (INIT_TIMEOUT_CYC < 1 || ADJ_TIMEOUT_CYC < 1)
    begin : g_bad_param
        $error("timeout counts must be at least one cycle");
    end

    typedef struct packed {
        adj_state_e  state;
        logic [15:0] req_code;
        logic        prepared;
        logic        restart_req;
        logic [15:0] run_code;
        logic [31:0] timer;
        logic        rsp_valid;
        logic [7:0]  rsp_code;
        logic [7:0]  rsp_mode;
        logic [15:0] rsp_size;
        logic [31:0] rsp_addr;
        logic [31:0] rsp_data;
        logic        warn_valid;
        logic [11:0] warn_code;
        logic [3:0]  start;
    } state_s;

    state_s cur_r;
    state_s cur_nxt;

    // ==========================================================
    // adjustment helpers
    function automatic logic needs_prep(input logic [15:0] c);
        needs_prep = (c == REQ_ABS_SET) || (c == REQ_MTURN);
    endfunction : needs_prep

    function automatic logic [3:0] op_onehot(input logic [15:0] c);
        case (c)
            REQ_PRM_INIT: op_onehot = 4'h1;
            REQ_ABS_SET:  op_onehot = 4'h2;
            REQ_CUR_OFS:  op_onehot = 4'h4;
            REQ_MTURN:    op_onehot = 4'h8;
            default:      op_onehot = 4'h0;
        endcase
    endfunction : op_onehot

    function automatic logic [3:0] byte_mask(input logic [2:0] n);
        case (n)
            3'h1:    byte_mask = 4'h1;
            3'h2:    byte_mask = 4'h3;
            3'h3:    byte_mask = 4'h7;
            default: byte_mask = 4'hf;
        endcase
    endfunction : byte_mask

    field_check_if fc ();
    assign fc.mode_type = cmd_mode_type_in;
    assign fc.size      = cmd_size_in;
    assign fc.addr      = cmd_addr_in;

    mem_field_check u_check (
        .fc (fc.checker_mp)
    );

    logic        is_mem;
    logic        is_wr;
    logic        cond_ok;
    logic [31:0] mem_word;
    logic [31:0] shifted;
    logic [15:0] ctrl_status;
    logic [15:0] wval;
    logic [3:0]  bmask;

    // ==========================================================
    // execution conditions of the selected request code
    always_comb
    begin
        case (cur_r.req_code)
            REQ_PRM_INIT: cond_ok = !servo_on_in;
            REQ_ABS_SET:  cond_ok = !servo_on_in
                                    && !incremental_enc_in;
            REQ_CUR_OFS:  cond_ok = main_power_in && !servo_on_in
                                    && !motor_rotating_in;
            REQ_MTURN:    cond_ok = 1'b1;
            default:      cond_ok = 1'b1;
        endcase
    end

    // ==========================================================
    // next state
    always_comb
    begin
        cur_nxt            = cur_r;
        cur_nxt.rsp_valid  = 1'b0;
        cur_nxt.warn_valid = 1'b0;
        cur_nxt.start      = 4'h0;
        is_mem   = (cmd_code_in == CMD_MEM_READ)
                   || (cmd_code_in == CMD_MEM_WRITE);
        is_wr    = (cmd_code_in == CMD_MEM_WRITE);
        wval     = cmd_data_in[15:0];
        bmask    = byte_mask(fc.nbytes);
        if (cur_r.state == ST_BUSY)
            ctrl_status = ADJ_ST_BUSY;
        else if (cur_r.prepared)
            ctrl_status = ADJ_ST_PREP;
        else
            ctrl_status = ADJ_ST_IDLE;
        mem_word = {ctrl_status, cur_r.req_code};
        shifted  = mem_word >> {fc.byte_off, 3'h0};

        // adjustment in progress: wait for done or time out
        if (cur_r.state == ST_BUSY)
        begin
            if (adj_done_in)
            begin
                cur_nxt.state    = ST_IDLE;
                cur_nxt.prepared = 1'b0;
                if (cur_r.run_code != REQ_CUR_OFS)
                    cur_nxt.restart_req = 1'b1;
            end
            else if (cur_r.timer == 32'h0)
            begin
                cur_nxt.state      = ST_IDLE;
                cur_nxt.prepared   = 1'b0;
                cur_nxt.warn_valid = 1'b1;
                cur_nxt.warn_code  = WARN_COND;
            end
            else
                cur_nxt.timer = cur_r.timer - 32'h1;
        end

        if (cmd_valid_in && is_mem)
        begin
            // echo of the command fields
            cur_nxt.rsp_valid = 1'b1;
            cur_nxt.rsp_code  = cmd_code_in;
            cur_nxt.rsp_mode  = cmd_mode_type_in;
            cur_nxt.rsp_size  = cmd_size_in;
            cur_nxt.rsp_addr  = cmd_addr_in;
            cur_nxt.rsp_data  = is_wr ? cmd_data_in : 32'h0;
            cur_nxt.warn_code = WARN_NONE;
            if (editing_in || (phase_in != PHASE_2
                               && phase_in != PHASE_3))
                cur_nxt.warn_code = WARN_COND;
            else if (fc.warn)
                cur_nxt.warn_code = fc.warn_code;
            else if (!is_wr)
                cur_nxt.rsp_data = shifted
                    & {{8{bmask[3]}}, {8{bmask[2]}},
                       {8{bmask[1]}}, {8{bmask[0]}}};
            else if (cur_r.state == ST_BUSY)
                cur_nxt.warn_code = WARN_COND;
            else if (!fc.byte_off[1])
            begin
                // request code location
                if (wval == REQ_NORMAL || op_onehot(wval) != 4'h0)
                begin
                    cur_nxt.req_code = wval;
                    cur_nxt.prepared = 1'b0;
                end
                else
                    cur_nxt.warn_code = WARN_COND;
            end
            else if (wval == CTRL_PREP && needs_prep(cur_r.req_code)
                     && cond_ok)
                cur_nxt.prepared = 1'b1;
            else if (wval == CTRL_EXEC && cond_ok
                     && (!needs_prep(cur_r.req_code) || cur_r.prepared))
            begin
                cur_nxt.start = op_onehot(cur_r.req_code);
                if (cur_r.req_code != REQ_NORMAL)
                begin
                    cur_nxt.state    = ST_BUSY;
                    cur_nxt.run_code = cur_r.req_code;
                    cur_nxt.timer    = (cur_r.req_code == REQ_PRM_INIT)
                                       ? 32'(INIT_TIMEOUT_CYC)
                                       : 32'(ADJ_TIMEOUT_CYC);
                end
            end
            else
                cur_nxt.warn_code = WARN_COND;
            cur_nxt.warn_valid = (cur_nxt.warn_code != WARN_NONE);
        end
    end

    // ==========================================================
    // state register
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            cur_r          <= '0;
            cur_r.state    <= ST_IDLE;
            cur_r.req_code <= REQ_RST;
        end
        else
            cur_r <= cur_nxt;
    end

    // ==========================================================
    // outputs
    assign rsp_valid_out          = cur_r.rsp_valid;
    assign rsp_code_out           = cur_r.rsp_code;
    assign rsp_mode_type_out      = cur_r.rsp_mode;
    assign rsp_size_out           = cur_r.rsp_size;
    assign rsp_addr_out           = cur_r.rsp_addr;
    assign rsp_data_out           = cur_r.rsp_data;
    assign warn_valid_out         = cur_r.warn_valid;
    assign warn_code_out          = cur_r.warn_code;
    assign command_ready_flag_out = (cur_r.state == ST_IDLE);
    assign adj_start_out          = cur_r.start;
    assign restart_required_out   = cur_r.restart_req;

    // ==========================================================
    // checks
    logic ok_ctx;
    assign ok_ctx = !editing_in && (phase_in == PHASE_2
                                    || phase_in == PHASE_3);

    echo_code_a: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in) cmd_valid_in && is_mem |=>
        rsp_valid_out && rsp_code_out == $past(cmd_code_in)
        && rsp_addr_out == $past(cmd_addr_in))
        else $error("memory command not echoed");
    wr_store_a: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in) rsp_valid_out && !warn_valid_out
        && rsp_code_out == CMD_MEM_WRITE && rsp_addr_out == ADJ_REQ_ADDR
        |-> cur_r.req_code == rsp_data_out[15:0])
        else $error("accepted write not stored");
    rd_reject_a: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in) cmd_valid_in && !is_wr && is_mem
        && ok_ctx && fc.warn |=> warn_valid_out && rsp_data_out == 32'h0)
        else $error("rejected read without warning");
    wr_discard_a: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in) cmd_valid_in && is_wr && fc.warn |=>
        warn_valid_out && $stable(cur_r.req_code) && $stable(cur_r.prepared))
        else $error("rejected write changed state");
    addr_warn_a: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in) cmd_valid_in && is_mem && ok_ctx
        && fc.warn_code == WARN_ADDR |=> warn_code_out == WARN_ADDR)
        else $error("address warning missing");
    type_warn_a: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in) cmd_valid_in && is_mem && ok_ctx
        && fc.warn_code == WARN_TYPE |=> warn_code_out == WARN_TYPE)
        else $error("type warning missing");
    size_warn_a: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in) cmd_valid_in && is_mem && ok_ctx
        && fc.warn_code == WARN_SIZE |=> warn_code_out == WARN_SIZE)
        else $error("size warning missing");
    edit_refuse_a: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in) cmd_valid_in && is_mem && editing_in |=>
        warn_valid_out && warn_code_out == WARN_COND)
        else $error("command taken while editing");
    init_servo_a: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in) adj_start_out[0] |-> !$past(servo_on_in))
        else $error("initialization started with servo on");
    ready_low_a: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in) adj_start_out != 4'h0 |->
        !command_ready_flag_out)
        else $error("ready during adjustment");
    restart_hold_a: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in) restart_required_out |=>
        restart_required_out)
        else $error("restart flag dropped");

endmodule : servo_memory_access_cmds
`default_nettype wire

// ---- testbench/servo_ctrl_model.sv ----
// controller stand-in that drives memory command frames
`timescale 1ns/1ps
`default_nettype none
module servo_ctrl_model
    import servo_mem_pkg::*;
(
    // clock
    input  wire logic        clk_sys_in,
    // command frame
    output logic             cmd_valid_out,
    output logic [7:0]       cmd_code_out,
    output logic [7:0]       cmd_mode_type_out,
    output logic [15:0]      cmd_size_out,
    output logic [31:0]      cmd_addr_out,
    output logic [31:0]      cmd_data_out
);
    // ==========================================================
    // idle frame at time zero
    initial
    begin
        cmd_valid_out     = 1'b0;
        cmd_code_out      = 8'h00;
        cmd_mode_type_out = 8'h00;
        cmd_size_out      = 16'h0000;
        cmd_addr_out      = 32'h0000_0000;
        cmd_data_out      = 32'h0000_0000;
    end

    // ==========================================================
    // one frame, held over the edge that takes it
    task automatic send(input logic [7:0] code, input logic [7:0] mt,
                        input logic [15:0] size, input logic [31:0] addr,
                        input logic [31:0] data);
        @(posedge clk_sys_in);
        #2;
        cmd_valid_out     = 1'b1;
        cmd_code_out      = code;
        cmd_mode_type_out = mt;
        cmd_size_out      = size;
        cmd_addr_out      = addr;
        cmd_data_out      = data;
        @(posedge clk_sys_in);
        #2;
        // stale fields are inverted so they never pass for a frame
        cmd_valid_out     = 1'b0;
        cmd_code_out      = ~code;
        cmd_mode_type_out = ~mt;
        cmd_size_out      = ~size;
        cmd_addr_out      = ~addr;
        cmd_data_out      = ~data;
    endtask : send
endmodule : servo_ctrl_model
`default_nettype wire

// ---- testbench/tb.sv ----
// self-checking bench for the memory command interpreter
`timescale 1ns/1ps
`default_nettype none
module tb;
    import servo_mem_pkg::*;
    localparam int ADJ_T  = 10;
    localparam int INIT_T = 20;
    logic        clk_sys_in = 1'b0;
    logic        rst_n_in, cmd_valid_in, editing_in, servo_on_in;
    logic        main_power_in, motor_rotating_in, incremental_enc_in;
    logic        adj_done_in, rsp_valid_out, warn_valid_out;
    logic        command_ready_flag_out, restart_required_out;
    logic [1:0]  phase_in;
    logic [7:0]  cmd_code_in, cmd_mode_type_in, rsp_code_out;
    logic [7:0]  rsp_mode_type_out;
    logic [15:0] cmd_size_in, rsp_size_out;
    logic [31:0] cmd_addr_in, cmd_data_in, rsp_addr_out, rsp_data_out;
    logic [11:0] warn_code_out;
    logic [3:0]  adj_start_out;
    int          miscompares = 0;
    int          check_count = 0;
    int          n;
    // bad-field table: address, type, size, expected warning
    logic [31:0] ta [5] = '{32'h8000_4004, ADJ_REQ_ADDR, ADJ_REQ_ADDR,
                            ADJ_REQ_ADDR, ADJ_CTRL_ADDR};
    logic [7:0]  tm [5] = '{MT_SHORT, 8'h14, MT_SHORT, MT_SHORT, MT_LONG};
    logic [15:0] ts [5] = '{16'h0001, 16'h0001, 16'h0000, 16'h0005,
                            16'h0001};
    logic [11:0] tw [5] = '{WARN_ADDR, WARN_TYPE, WARN_SIZE, WARN_SIZE,
                            WARN_SIZE};

    // ==========================================================
    // clock and design instances
    always #25 clk_sys_in = ~clk_sys_in;

    servo_ctrl_model i_servo_ctrl_model (
        .clk_sys_in        (clk_sys_in),
        .cmd_valid_out     (cmd_valid_in),
        .cmd_code_out      (cmd_code_in),
        .cmd_mode_type_out (cmd_mode_type_in),
        .cmd_size_out      (cmd_size_in),
        .cmd_addr_out      (cmd_addr_in),
        .cmd_data_out      (cmd_data_in)
    );

    servo_memory_access_cmds #(
        .INIT_TIMEOUT_CYC (INIT_T),
        .ADJ_TIMEOUT_CYC  (ADJ_T)
    ) i_servo_memory_access_cmds (.*);

    // ==========================================================
    // verdict and run end
    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : final_report

    // value compare
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        check_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    // one command with its answer and warning checked
    task automatic xfer(input logic [7:0] code, input logic [31:0] addr,
                        input logic [31:0] data, input logic [7:0] mt,
                        input logic [15:0] size, input logic [11:0] ew);
        i_servo_ctrl_model.send(code, mt, size, addr, data);
        chk(rsp_valid_out, 1'b1, "response pulse");
        chk(rsp_code_out, code, "code echo");
        chk(rsp_addr_out, addr, "address echo");
        chk(rsp_mode_type_out, mt, "type echo");
        chk(rsp_size_out, size, "size echo");
        chk(warn_valid_out, ew != WARN_NONE, "warning pulse");
        if (ew != WARN_NONE)
            chk(warn_code_out, ew, "warning code");
        if (code == CMD_MEM_WRITE && ew == WARN_NONE)
            chk(rsp_data_out, data, "write echo");
    endtask : xfer

    // read with expected data
    task automatic rd(input logic [31:0] addr, input logic [7:0] mt,
                      input logic [15:0] size, input logic [31:0] exp);
        xfer(CMD_MEM_READ, addr, 32'h0, mt, size, WARN_NONE);
        chk(rsp_data_out, exp, "read data");
    endtask : rd

    // write to one adjustment location
    task automatic wr(input logic [31:0] addr, input logic [15:0] val,
                      input logic [11:0] ew);
        xfer(CMD_MEM_WRITE, addr, {16'h0, val}, MT_SHORT, 16'h0001, ew);
    endtask : wr

    // bounded wait for the ready status
    task automatic wait_ready();
        n = 0;
        while (command_ready_flag_out !== 1'b1 && n < 40)
        begin
            @(posedge clk_sys_in);
            #2;
            n++;
        end
        chk(command_ready_flag_out, 1'b1, "ready returns");
        if (n >= 40)
            final_report();
    endtask : wait_ready

    // engine reports completion when pulse is set, then the sequence is finished
    task automatic finish(input logic pulse);
        if (pulse)
        begin
            @(posedge clk_sys_in);
            #2;
            adj_done_in = 1'b1;
            @(posedge clk_sys_in);
            #2;
            adj_done_in = 1'b0;
            wait_ready();
        end
        wr(ADJ_REQ_ADDR, REQ_NORMAL, WARN_NONE);
        wait_ready();
    endtask : finish

    // request, optional preparation, execution
    task automatic adj(input logic [15:0] req, input logic prep,
                       input logic [11:0] ew, input logic [3:0] start_e,
                       input logic done);
        wr(ADJ_REQ_ADDR, req, WARN_NONE);
        if (prep)
        begin
            wr(ADJ_CTRL_ADDR, CTRL_PREP, WARN_NONE);
            rd(VMEM_BASE, MT_LONG, 16'h0001, {ADJ_ST_PREP, req});
            rd(32'h8000_4001, MT_BYTE, 16'h0001, {24'h0, req[15:8]});
        end
        wr(ADJ_CTRL_ADDR, CTRL_EXEC, ew);
        if (ew == WARN_NONE)
        begin
            chk(adj_start_out, start_e, "start pulse");
            chk(command_ready_flag_out, 1'b0, "busy");
            rd(ADJ_CTRL_ADDR, MT_SHORT, 16'h0001,
               {16'h0, ADJ_ST_BUSY});
        end
        if (done)
            finish(ew == WARN_NONE);
    endtask : adj

    // ==========================================================
    // main sequence
    initial
    begin
        rst_n_in = 1'b0;
        adj_done_in = 1'b0;
        phase_in = PHASE_2;
        editing_in = 1'b0;
        servo_on_in = 1'b0;
        main_power_in = 1'b1;
        motor_rotating_in = 1'b0;
        incremental_enc_in = 1'b0;
        repeat (10) @(posedge clk_sys_in);
        #2;
        rst_n_in = 1'b1;
        chk(command_ready_flag_out, 1'b1, "ready at reset");
        chk(restart_required_out, 1'b0, "restart at reset");
        rd(ADJ_REQ_ADDR, MT_SHORT, 16'h0001, 32'h0);
        for (int i = 0; i < 5; i++)
        begin
            xfer(CMD_MEM_READ, ta[i], 32'h0, tm[i], ts[i], tw[i]);
            chk(rsp_data_out, 32'h0, "rejected read data");
            xfer(CMD_MEM_WRITE, ta[i], 32'h1005, tm[i], ts[i], tw[i]);
            rd(ADJ_REQ_ADDR, MT_SHORT, 16'h0001, 32'h0);
        end
        i_servo_ctrl_model.send(8'h30, MT_SHORT, 16'h0001, ADJ_REQ_ADDR,
                                32'h0000_1005);
        chk(rsp_valid_out, 1'b0, "other code ignored");
        editing_in = 1'b1;
        wr(ADJ_REQ_ADDR, REQ_PRM_INIT, WARN_COND);
        editing_in = 1'b0;
        phase_in = 2'h1;
        wr(ADJ_REQ_ADDR, REQ_PRM_INIT, WARN_COND);
        phase_in = PHASE_3;
        rd(ADJ_REQ_ADDR, MT_SHORT, 16'h0001, 32'h0);
        $display("test fields done");
        main_power_in = 1'b0;
        adj(REQ_CUR_OFS, 1'b0, WARN_COND, 4'h0, 1'b1);
        main_power_in = 1'b1;
        motor_rotating_in = 1'b1;
        adj(REQ_CUR_OFS, 1'b0, WARN_COND, 4'h0, 1'b1);
        motor_rotating_in = 1'b0;
        adj(REQ_CUR_OFS, 1'b0, WARN_NONE, 4'h4, 1'b1);
        chk(restart_required_out, 1'b0, "no restart after offset");
        servo_on_in = 1'b1;
        adj(REQ_PRM_INIT, 1'b0, WARN_COND, 4'h0, 1'b1);
        servo_on_in = 1'b0;
        adj(REQ_PRM_INIT, 1'b0, WARN_NONE, 4'h1, 1'b1);
        chk(restart_required_out, 1'b1, "restart after init");
        incremental_enc_in = 1'b1;
        wr(ADJ_REQ_ADDR, REQ_ABS_SET, WARN_NONE);
        wr(ADJ_CTRL_ADDR, CTRL_PREP, WARN_COND);
        incremental_enc_in = 1'b0;
        adj(REQ_ABS_SET, 1'b0, WARN_COND, 4'h0, 1'b1);
        adj(REQ_ABS_SET, 1'b1, WARN_NONE, 4'h2, 1'b1);
        adj(REQ_MTURN, 1'b1, WARN_NONE, 4'h8, 1'b0);
        wr(ADJ_REQ_ADDR, REQ_PRM_INIT, WARN_COND);
        finish(1'b1);
        wr(ADJ_REQ_ADDR, 16'h1234, WARN_COND);
        $display("test adjustments done");
        adj(REQ_CUR_OFS, 1'b0, WARN_NONE, 4'h4, 1'b0);
        n = 0;
        while (warn_valid_out !== 1'b1 && n < ADJ_T + 20)
        begin
            @(posedge clk_sys_in);
            #2;
            n++;
        end
        chk(warn_valid_out, 1'b1, "timeout pulse");
        if (n >= ADJ_T + 20)
            final_report();
        chk(warn_code_out, WARN_COND, "timeout warning");
        chk(command_ready_flag_out, 1'b1, "ready after timeout");
        finish(1'b0);
        $display("test timeout done");
        final_report();
    end
endmodule : tb
`default_nettype wire
